// ---- design/cpc_regs.sv ----
`timescale 1ns/1ps
module cpc_regs (
   // clock, reset, enable
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic                         ce,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [cpc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [cpc_pkg::DATA_W-1:0]   pwdata,
   input  wire logic [3:0]                   pstrb,
   output logic      [cpc_pkg::DATA_W-1:0]   prdata,
   output logic                              pready,
   output logic                              pslverr,
   // channel type of channels 1 to 4
   input  wire logic [cpc_pkg::ANALOG_CH-1:0] chanIsPdm,
   // power controls
   output logic                              micBiasOn,
   output logic                              pllOn,
   output logic      [cpc_pkg::ANALOG_CH-1:0] analogPowerOn,
   output logic      [cpc_pkg::NUM_CH-1:0]   pdmPowerOn,
   // serial output slots
   output logic      [cpc_pkg::NUM_CH-1:0]   slotDriveEn,
   // gain controller settings
   output logic                              gainCtrlActive,
   output logic signed [6:0]                 gainTargetDb,
   output logic      [5:0]                   gainMaxDb
);
   import cpc_pkg::*;

   // ==========================================================
   // registers
   logic              gainSel_q;
   logic [7:0]        gainCfg_q;
   logic [7:0]        inEn_q;
   logic [7:0]        slotEn_q;
   logic [7:0]        pwr_q;
   logic [31:0]       prdata_q;
   logic              setupSeen_q;
   logic              gainAct_q;
   logic signed [6:0] tgtDb_q;
   logic [5:0]        maxDb_q;
   logic [3:0]        analog_q;
   logic [7:0]        pdm_q;

   cpc_pwr_if pw ();

   // ==========================================================
   // address decode
   wire logic [7:0]  regIdx     = paddr[9:2];
   wire logic        alignedLow = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
   wire logic        hitGainSel = alignedLow && (regIdx == IDX_GAIN_SEL);
   wire logic        hitGainCfg = alignedLow && (regIdx == IDX_GAIN_CFG);
   wire logic        hitInEn    = alignedLow && (regIdx == IDX_IN_EN);
   wire logic        hitSlotEn  = alignedLow && (regIdx == IDX_SLOT_EN);
   wire logic        hitPwr     = alignedLow && (regIdx == IDX_PWR);
   wire logic        hitChSts   = alignedLow && (regIdx == IDX_CH_STS);
   wire logic        hitModeSts = alignedLow && (regIdx == IDX_MODE_STS);
   wire logic        hitRw      = hitGainSel | hitGainCfg | hitInEn | hitSlotEn | hitPwr;
   wire logic        hitRo      = hitChSts | hitModeSts;
   wire logic        badAccess  = !(hitRw | hitRo) | (pwrite & hitRo);

   // ==========================================================
   // handshake
   assign pready  = ce & psel & penable & setupSeen_q;
   assign pslverr = pready & badAccess;

   wire logic        wrDone  = pready & pwrite & !badAccess & pstrb[0];
   wire logic [7:0]  wrByte  = pwdata[7:0];
   wire logic        wrGSel  = wrDone & hitGainSel;
   wire logic        wrGCfg  = wrDone & hitGainCfg;
   wire logic        wrInEn  = wrDone & hitInEn;
   wire logic        wrSlot  = wrDone & hitSlotEn;
   wire logic        wrPwr   = wrDone & hitPwr;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         setupSeen_q <= 1'b0;
      end else if (ce) begin
         setupSeen_q <= psel & !pready;
      end
   end

   // ==========================================================
   // read mux
   wire logic [7:0]  gainSelRd = {4'h0, gainSel_q, 3'h0};
   wire logic [7:0]  modeRd    = {pw.modeStatus, 5'h00};
   wire logic [7:0]  readByte  = ({8{hitGainSel}} & gainSelRd)
                               | ({8{hitGainCfg}} & gainCfg_q)
                               | ({8{hitInEn}}    & inEn_q)
                               | ({8{hitSlotEn}}  & slotEn_q)
                               | ({8{hitPwr}}     & pwr_q)
                               | ({8{hitChSts}}   & pw.channelPower)
                               | ({8{hitModeSts}} & modeRd);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_q <= 32'h0000_0000;
      end else if (ce && psel && !pwrite) begin
         prdata_q <= {24'h00_0000, readByte};
      end
   end

   assign prdata = prdata_q;

   // ==========================================================
   // writable registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gainSel_q <= RST_GAIN_SEL;
      end else if (ce && wrGSel) begin
         gainSel_q <= wrByte[BIT_GAIN_SEL];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gainCfg_q <= RST_GAIN_CFG;
      end else if (ce && wrGCfg) begin
         gainCfg_q <= wrByte;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inEn_q <= RST_IN_EN;
      end else if (ce && wrInEn) begin
         inEn_q <= wrByte;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slotEn_q <= RST_SLOT_EN;
      end else if (ce && wrSlot) begin
         slotEn_q <= wrByte;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_q <= RST_PWR;
      end else if (ce && wrPwr) begin
         pwr_q <= wrByte;
      end
   end

   // ==========================================================
   // channel power control
   assign pw.converterOn = pwr_q[BIT_CONV];
   assign pw.dynEnable   = pwr_q[BIT_DYN];
   assign pw.maxGroup    = pwr_q[GRP_LO +: 2];
   assign pw.inEnables   = inEn_q;

   cpc_power_ctrl u_power (
      .clk    (clk),
      .arst_n (arst_n),
      .ce     (ce),
      .pw     (pw.ctrl)
   );

   // channels 1-4 split by type, channels 5-8 pdm only
   wire logic [3:0] upperPower = pw.channelPower[NUM_CH-1 -: ANALOG_CH];
   wire logic [3:0] analogD    = upperPower & ~chanIsPdm;
   wire logic [7:0] pdmD       = {upperPower & chanIsPdm, pw.channelPower[ANALOG_CH-1:0]};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         analog_q <= 4'h0;
         pdm_q    <= 8'h00;
      end else if (ce) begin
         analog_q <= analogD;
         pdm_q    <= pdmD;
      end
   end

   assign analogPowerOn = analog_q;
   assign pdmPowerOn    = pdm_q;
   assign micBiasOn     = pwr_q[BIT_MICBIAS];
   assign pllOn         = pwr_q[BIT_PLL];
   assign slotDriveEn   = slotEn_q;

   // ==========================================================
   // gain controller decode
   wire logic [3:0]        tgtCode  = gainCfg_q[TGT_LO +: 4];
   wire logic [3:0]        maxCode  = gainCfg_q[MAXG_LO +: 4];
   wire logic [3:0]        maxClamp = (maxCode > MAXG_TOP) ? MAXG_TOP : maxCode;
   wire logic signed [6:0] tgtDbD   = TGT_BASE_DB - $signed({2'b00, tgtCode, 1'b0});
   wire logic [5:0]        maxDbD   = 6'(({2'b00, maxClamp} + 6'h01) * MAXG_STEP_DB);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gainAct_q <= 1'b0;
         tgtDb_q   <= 7'sh00;
         maxDb_q   <= 6'h00;
      end else if (ce) begin
         gainAct_q <= gainSel_q;
         tgtDb_q   <= gainSel_q ? tgtDbD : 7'sh00;
         maxDb_q   <= gainSel_q ? maxDbD : 6'h00;
      end
   end

   assign gainCtrlActive = gainAct_q;
   assign gainTargetDb   = tgtDb_q;
   assign gainMaxDb      = maxDb_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_target_level: assert property (ce && gainSel_q |=> gainTargetDb ==
      -7'sd6 - 7'sd2 * $signed({3'b000, $past(tgtCode)}))
      else $error("target level decode wrong");
   a_max_gain: assert property (ce && gainSel_q && maxCode <= 4'hD |=>
      gainMaxDb == 6'd3 * (6'd1 + {2'b00, $past(maxCode)}))
      else $error("max gain decode wrong");
   a_gain_gated: assert property (ce && !gainSel_q |=> !gainCtrlActive
      && gainTargetDb == 7'sh00 && gainMaxDb == 6'h00)
      else $error("gain settings act while enhancer selected");
   a_in_en_write: assert property (ce && wrInEn |=> inEn_q == $past(pwdata[7:0]))
      else $error("input enable write lost");
   a_pdm_only: assert property (ce |=> analogPowerOn ==
      ($past(pw.channelPower[7:4]) & ~$past(chanIsPdm))
      && pdmPowerOn[3:0] == $past(pw.channelPower[3:0]))
      else $error("upper channels routed as analog");
   a_slot_write: assert property (ce && wrSlot |=> slotDriveEn == $past(pwdata[7:0]))
      else $error("slot enable write lost");
   a_bias_write: assert property (ce && wrPwr |=> micBiasOn == $past(pwdata[7]))
      else $error("bias control write lost");
   a_pll_write: assert property (ce && wrPwr |=> pllOn == $past(pwdata[5]))
      else $error("pll control write lost");
   a_unmapped_err: assert property (pready && badAccess |-> pslverr
      ##1 ($stable(inEn_q) && $stable(slotEn_q) && $stable(pwr_q)
      && $stable(gainCfg_q) && $stable(gainSel_q)))
      else $error("refused access not blocked");

   c_read_status: cover property (pready && !pwrite && hitChSts && prdata[7:0] != 8'h00);
   c_gain_on: cover property (ce && wrGSel && pwdata[3] ##2 gainCtrlActive);
endmodule

// ---- common/cpc_pkg.sv ----
// What this block does
// - Target-level field bits 7..4 picks -6 dB minus 2 dB per code, -36 dB at code 15, reset 14.
// - Max-gain field bits 3..0 picks 3 dB per step from 3 dB to 42 dB at code 13, reset 7.
// - Input enable register holds channel 1 at bit 7 down to channel 8 at bit 0, reset F0h.
// - Channels 5 to 8 can only ever be powered as PDM channels, never as analog converters.
// - Each serial output slot is driven when its bit is 1 and left floating when 0, reset 0.
// - Power bit 7 turns the microphone bias on when 1 and off when 0, reset 0.
// - Power bit 6 powers the enabled channels, limited by bits 4..2 as below, when 1 and none of them when 0.
// - Power bit 5 turns the PLL on when 1 and off when 0, reset 0.
// - Power bit 4 lets channels change while recording; when 0, changes wait until idle.
// - With dynamic control, bits 3..2 cap the channels at 1-2, 1-4, 1-6 or 1-8.
// - Gain controller settings act only while the range-enhancer/gain select bit is 1.
package cpc_pkg;

   // ==========================================================
   // bus and register indices (byte address is four times)
   localparam int unsigned ADDR_W       = 12;
   localparam int unsigned DATA_W       = 32;
   localparam logic [7:0]  IDX_GAIN_SEL = 8'h6C;
   localparam logic [7:0]  IDX_GAIN_CFG = 8'h70;
   localparam logic [7:0]  IDX_IN_EN    = 8'h73;
   localparam logic [7:0]  IDX_SLOT_EN  = 8'h74;
   localparam logic [7:0]  IDX_PWR      = 8'h75;
   localparam logic [7:0]  IDX_CH_STS   = 8'h76;
   localparam logic [7:0]  IDX_MODE_STS = 8'h77;

   // ==========================================================
   // reset values
   localparam logic [7:0]  RST_GAIN_CFG = 8'hE7;
   localparam logic [7:0]  RST_IN_EN    = 8'hF0;
   localparam logic [7:0]  RST_SLOT_EN  = 8'h00;
   localparam logic [7:0]  RST_PWR      = 8'h00;
   localparam logic        RST_GAIN_SEL = 1'b0;

   // ==========================================================
   // field positions
   localparam int unsigned TGT_LO       = 4;
   localparam int unsigned MAXG_LO      = 0;
   localparam int unsigned BIT_GAIN_SEL = 3;
   localparam int unsigned BIT_MICBIAS  = 7;
   localparam int unsigned BIT_CONV     = 6;
   localparam int unsigned BIT_PLL      = 5;
   localparam int unsigned BIT_DYN      = 4;
   localparam int unsigned GRP_LO       = 2;
   localparam int unsigned MODE_LO      = 5;

   // ==========================================================
   // channels, gain mapping, mode codes
   localparam int unsigned NUM_CH       = 8;
   localparam int unsigned ANALOG_CH    = 4;
   localparam logic signed [6:0] TGT_BASE_DB = -7'sd6;
   localparam logic [3:0]  MAXG_TOP     = 4'hD;
   localparam logic [5:0]  MAXG_STEP_DB = 6'h03;
   localparam logic [2:0]  MODE_SLEEP   = 3'h4;
   localparam logic [2:0]  MODE_IDLE    = 3'h6;
   localparam logic [2:0]  MODE_ACTIVE  = 3'h7;

   typedef enum logic [1:0] {
      PS_IDLE = 2'b01,
      PS_REC  = 2'b10
   } cpc_pwr_state_t;

endpackage

// ---- common/cpc_pwr_if.sv ----
`timescale 1ns/1ps
interface cpc_pwr_if;
   logic       converterOn;
   logic       dynEnable;
   logic [1:0] maxGroup;
   logic [7:0] inEnables;
   logic [7:0] channelPower;
   logic [2:0] modeStatus;

   modport regs (
      output converterOn,
      output dynEnable,
      output maxGroup,
      output inEnables,
      input  channelPower,
      input  modeStatus
   );
   modport ctrl (
      input  converterOn,
      input  dynEnable,
      input  maxGroup,
      input  inEnables,
      output channelPower,
      output modeStatus
   );
endinterface

// ---- design/cpc_power_ctrl.sv ----
`timescale 1ns/1ps
module cpc_power_ctrl (
   // clock, reset, enable
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   // register side
   cpc_pwr_if.ctrl   pw
);
   import cpc_pkg::*;

   // ==========================================================
   // state
   cpc_pwr_state_t state_q;
   cpc_pwr_state_t state_d;
   logic [7:0]     applied_q;
   logic [7:0]     applied_d;
   logic [7:0]     power_q;
   logic [7:0]     power_d;
   logic [2:0]     mode_q;
   logic [2:0]     mode_d;
   logic [7:0]     groupMask;
   logic           updateOk;

   // ==========================================================
   // per-channel group cap and power
   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_ch
         assign groupMask[i] = (NUM_CH - 1 - i) < (2 * (int'(pw.maxGroup) + 1));
         assign power_d[i]   = pw.converterOn & (updateOk
                             ? applied_d[i] & (~pw.dynEnable | groupMask[i])
                             : power_q[i]);
      end
   endgenerate

   always_comb begin
      unique case (state_q)
         PS_IDLE: updateOk = 1'b1;
         PS_REC:  updateOk = pw.dynEnable;
         default: updateOk = 1'b1;
      endcase
   end

   assign applied_d = updateOk ? pw.inEnables : applied_q;
   assign state_d   = (|power_d) ? PS_REC : PS_IDLE;
   assign mode_d    = !pw.converterOn ? MODE_SLEEP : ((|power_d) ? MODE_ACTIVE : MODE_IDLE);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q   <= PS_IDLE;
         applied_q <= 8'h00;
         power_q   <= 8'h00;
         mode_q    <= MODE_SLEEP;
      end else if (ce) begin
         state_q   <= state_d;
         applied_q <= applied_d;
         power_q   <= power_d;
         mode_q    <= mode_d;
      end
   end

   assign pw.channelPower = power_q;
   assign pw.modeStatus   = mode_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   a_conv_off_all: assert property (ce && !pw.converterOn |=> power_q == 8'h00)
      else $error("channels stay powered with converter power off");
   a_static_start: assert property (
      ce && pw.converterOn && !pw.dynEnable && power_q == 8'h00
      |=> power_q == $past(pw.inEnables))
      else $error("enabled channels not powered on start");
   a_static_hold: assert property (
      ce && pw.converterOn && !pw.dynEnable && |power_q
      |=> power_q == $past(power_q))
      else $error("channel power changed while recording without dynamic mode");
   a_dyn_follow: assert property (
      ce && pw.converterOn && pw.dynEnable && pw.maxGroup == 2'h3
      |=> power_q == $past(pw.inEnables))
      else $error("dynamic mode does not follow enables");
   a_group_cap: assert property (ce && pw.dynEnable && pw.maxGroup == 2'h0
      |=> power_q[5:0] == 6'h00)
      else $error("channel above group powered");
   a_mode_code: assert property (ce |=> mode_q == (!$past(pw.converterOn) ? MODE_SLEEP
      : ((|power_q) ? MODE_ACTIVE : MODE_IDLE)))
      else $error("mode status wrong");

   c_dyn_change: cover property (ce && pw.dynEnable && |power_q ##1 power_q != $past(power_q));
   c_held_change: cover property (state_q == PS_REC && !pw.dynEnable
      && pw.inEnables != applied_q);
endmodule

// ---- tb/cpc_host_model.sv ----
`timescale 1ns/1ps
module cpc_host_model (
   // clock
   input  wire logic                       clk,
   // apb master
   output logic                            psel,
   output logic                            penable,
   output logic                            pwrite,
   output logic [cpc_pkg::ADDR_W-1:0]      paddr,
   output logic [cpc_pkg::DATA_W-1:0]      pwdata,
   output logic [3:0]                      pstrb,
   input  wire logic                       pready
);
   import cpc_pkg::*;

   // ==========================================================
   // idle levels
   initial begin
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = '0;
      pwdata  = '0;
      pstrb   = 4'h0;
   end

   // ==========================================================
   // one transfer, held until pready at a rising edge
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
      logic [31:0] v;
      v = wd;
      if (idx == IDX_PWR) v[1:0] = 2'h0;
      if (idx == IDX_GAIN_CFG && v[3:0] > MAXG_TOP) v[3:0] = MAXG_TOP;
      @(posedge clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= v;
      pstrb   <= st;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      psel    <= 1'h0;
      penable <= 1'h0;
      pwdata  <= ~v;
      paddr   <= ~paddr;
   endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import cpc_pkg::*;

   typedef struct packed {
      logic [31:0] d;
      logic        e;
      logic        r;
   } cpc_note_t;

   // ==========================================================
   // signals
   logic                     clk;
   logic                     arst_n;
   logic                     ce;
   logic [ANALOG_CH-1:0]     chanIsPdm;
   wire logic                psel;
   wire logic                penable;
   wire logic                pwrite;
   wire logic [ADDR_W-1:0]   paddr;
   wire logic [DATA_W-1:0]   pwdata;
   wire logic [3:0]          pstrb;
   wire logic [DATA_W-1:0]   prdata;
   wire logic                pready;
   wire logic                pslverr;
   wire logic                micBiasOn;
   wire logic                pllOn;
   wire logic [ANALOG_CH-1:0] analogPowerOn;
   wire logic [NUM_CH-1:0]   pdmPowerOn;
   wire logic [NUM_CH-1:0]   slotDriveEn;
   wire logic                gainCtrlActive;
   wire logic signed [6:0]   gainTargetDb;
   wire logic [5:0]          gainMaxDb;
   cpc_note_t                notes[$];
   cpc_note_t                nt;
   int                       failCount;
   int                       samplesChecked;
   int                       cycles;
   logic [7:0]               v;
   logic [7:0]               st;

   cpc_regs i_dut (
      .clk(clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chanIsPdm(chanIsPdm), .micBiasOn(micBiasOn),
      .pllOn(pllOn), .analogPowerOn(analogPowerOn), .pdmPowerOn(pdmPowerOn),
      .slotDriveEn(slotDriveEn), .gainCtrlActive(gainCtrlActive),
      .gainTargetDb(gainTargetDb), .gainMaxDb(gainMaxDb)
   );
   cpc_host_model i_host (
      .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready)
   );

   // ==========================================================
   // clock, timeout
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failCount++;
         completeRun();
      end
   end

   // ==========================================================
   // shared tasks
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic e);
      notes.push_back('{d: d, e: e, r: 1'h1});
      i_host.xfer(1'h0, idx, 32'h0, 4'hF);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                     input logic e);
      notes.push_back('{d: 32'h0, e: e, r: 1'h0});
      i_host.xfer(1'h1, idx, {24'h0, d}, s);
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic completeRun();
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ==========================================================
   // monitor: oldest note against each completed transfer
   always @(negedge clk) begin
      if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
         if (notes.size() == 0) check("note queue", 32'h1, 32'h0);
         else begin
            nt = notes.pop_front();
            check("pslverr", 32'(pslverr), 32'(nt.e));
            if (nt.r) check("prdata", prdata, nt.d);
         end
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      clk = 1'h0;
      arst_n = 1'h0;
      ce = 1'h1;
      chanIsPdm = 4'h3;
      failCount = 0;
      samplesChecked = 0;
      cycles = 0;
      v = 8'($urandom(32'hbe4f));
      repeat (10) @(posedge clk);
      arst_n <= 1'h1;
      // reset values
      rd(IDX_GAIN_CFG, 32'hE7, 1'h0);
      rd(IDX_IN_EN, 32'hF0, 1'h0);
      rd(IDX_SLOT_EN, 32'h0, 1'h0);
      rd(IDX_PWR, 32'h0, 1'h0);
      check("slotDriveEn", 32'(slotDriveEn), 32'h0);
      // refused places
      rd(8'h71, 32'h0, 1'h1);
      wr(IDX_CH_STS, 8'hFF, 4'h1, 1'h1);
      // serial slots, random pattern, masked write ignored
      v = 8'($urandom);
      wr(IDX_SLOT_EN, v, 4'h1, 1'h0);
      wr(IDX_SLOT_EN, ~v, 4'h0, 1'h0);
      settle();
      check("slotDriveEn", 32'(slotDriveEn), 32'(v));
      rd(IDX_SLOT_EN, 32'(v), 1'h0);
      // bias and pll, converter bit clear
      for (int k = 0; k < 4; k++) begin
         wr(IDX_PWR, {k[1], 1'h0, k[0], 5'h0}, 4'h1, 1'h0);
         settle();
         check("micBiasOn", 32'(micBiasOn), 32'(k[1]));
         check("pllOn", 32'(pllOn), 32'(k[0]));
         check("analogPowerOn", 32'(analogPowerOn), 32'h0);
      end
      // gain controller selected, every target code, max-gain codes 0 to 13
      wr(IDX_GAIN_SEL, 8'h08, 4'h1, 1'h0);
      rd(IDX_GAIN_SEL, 32'h08, 1'h0);
      for (int k = 0; k < 16; k++) begin
         wr(IDX_GAIN_CFG, {4'(k), 4'(k % 14)}, 4'h1, 1'h0);
         settle();
         check("gainTargetDb", 32'(gainTargetDb), 32'(-6 - 2 * k));
         check("gainMaxDb", 32'(gainMaxDb), 32'(3 * (k % 14 + 1)));
         check("gainCtrlActive", 32'(gainCtrlActive), 32'h1);
      end
      wr(IDX_GAIN_SEL, 8'h00, 4'h1, 1'h0);
      settle();
      check("gainCtrlActive", 32'(gainCtrlActive), 32'h0);
      check("gainMaxDb", 32'(gainMaxDb), 32'h0);
      // static power-up, then enable change while recording
      wr(IDX_IN_EN, 8'hF8, 4'h1, 1'h0);
      wr(IDX_PWR, 8'hC0, 4'h1, 1'h0);
      settle();
      rd(IDX_CH_STS, 32'hF8, 1'h0);
      check("analogPowerOn", 32'(analogPowerOn), 32'hC);
      check("pdmPowerOn", 32'(pdmPowerOn), 32'h38);
      rd(IDX_MODE_STS, 32'hE0, 1'h0);
      wr(IDX_IN_EN, 8'hFF, 4'h1, 1'h0);
      settle();
      rd(IDX_CH_STS, 32'hF8, 1'h0);
      // dynamic mode, every group cap
      for (int g = 0; g < 4; g++) begin
         @(posedge clk);
         chanIsPdm <= 4'($urandom);
         wr(IDX_PWR, 8'hD0 | 8'(g << 2), 4'h1, 1'h0);
         settle();
         st = 8'hFF << (6 - 2 * g);
         rd(IDX_CH_STS, 32'(st), 1'h0);
         check("analogPowerOn", 32'(analogPowerOn), 32'(st[7:4] & ~chanIsPdm));
         check("pdmPowerOn", 32'(pdmPowerOn), 32'({st[7:4] & chanIsPdm, st[3:0]}));
      end
      // converter off overrides enables
      wr(IDX_PWR, 8'h10, 4'h1, 1'h0);
      settle();
      rd(IDX_CH_STS, 32'h0, 1'h0);
      rd(IDX_MODE_STS, 32'h80, 1'h0);
      check("pdmPowerOn", 32'(pdmPowerOn), 32'h0);
      wr(IDX_IN_EN, 8'h00, 4'h1, 1'h0);
      wr(IDX_PWR, 8'h40, 4'h1, 1'h0);
      settle();
      rd(IDX_MODE_STS, 32'hC0, 1'h0);
      // second reset mid-run
      arst_n <= 1'h0;
      @(posedge clk);
      arst_n <= 1'h1;
      rd(IDX_IN_EN, 32'hF0, 1'h0);
      rd(IDX_PWR, 32'h0, 1'h0);
      check("slotDriveEn", 32'(slotDriveEn), 32'h0);
      completeRun();
   end
endmodule
